// *** bench/tpc_host_model.sv ***
// Host model: sends control bytes on the serial link, MSB first.
// Assumes i_clk at 50 ns; shift clock 400 ns, low outside frames.
`timescale 1ns/1ps
module tpc_host_model (
  input  wire logic i_clk,
  output logic      o_sel_n,
  output logic      o_sclk,
  output logic      o_sdin
);
  initial begin
    o_sel_n = 1'b1;
    o_sclk  = 1'b0;
    o_sdin  = 1'b0;
  end
  // Caller picks every field, external reference included
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    o_sel_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int i = 7; i >= 0; i--) begin
      o_sdin <= b[i];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    o_sel_n <= 1'b1;
    o_sdin  <= ~b[0];
  endtask
endmodule

// *** bench/tpc_top_tb_top.sv ***
// Self-checking bench of the touch converter control block.
// Assumes a host model on the serial pins and a 20 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tpc_top_tb_top import tpc_pkg::*; ;
  logic       i_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       i_touch_sense_n = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       sel_n, sclk, sdin;
  logic [7:0] o_rdata;
  logic       o_irq, o_touch_alert_n, o_touch_alert_oe_n, o_adc_powered;
  logic       o_xplate_on, o_yplate_on, o_yneg_gnd, o_sense_on_xpos, o_mux_valid;
  logic       o_ref_external, o_res_8bit;
  logic [1:0] o_mux_sel;
  int         num_errors = 0;
  int         checks_done = 0;
  logic [31:0] seed = 32'h0000004B;
  logic [7:0] sent[$];
  logic [7:0] d;
  logic [2:0] chans[4] = '{CHAN_XPOS, CHAN_YPOS, CHAN_AUX_A, CHAN_AUX_B};
  always #25 i_clk = ~i_clk;
  tpc_host_model HOST (.i_clk(i_clk), .o_sel_n(sel_n), .o_sclk(sclk), .o_sdin(sdin));
  tpc_top DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sel_n(sel_n), .i_serial_shift_clock(sclk),
    .i_sdin(sdin), .i_touch_sense_n(i_touch_sense_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_touch_alert_n(o_touch_alert_n),
    .o_touch_alert_oe_n(o_touch_alert_oe_n), .o_adc_powered(o_adc_powered), .o_xplate_on(o_xplate_on),
    .o_yplate_on(o_yplate_on), .o_yneg_gnd(o_yneg_gnd), .o_sense_on_xpos(o_sense_on_xpos),
    .o_mux_sel(o_mux_sel), .o_mux_valid(o_mux_valid), .o_ref_external(o_ref_external),
    .o_res_8bit(o_res_8bit));
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [31:0] rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 v = o_rdata;
  endtask
  // Model: outputs expected from the last control byte
  task automatic check_ctrl(input logic [7:0] b);
    logic [2:0] c;
    logic [1:0] p;
    logic       aux;
    c   = b[6:4];
    p   = b[1:0];
    aux = (c == CHAN_AUX_A) || (c == CHAN_AUX_B);
    `CHK(o_adc_powered, p == PWR_ALWAYS_ON)
    `CHK(o_yneg_gnd, p == PWR_SLEEP_ALERT)
    `CHK(o_sense_on_xpos, p == PWR_SLEEP_ALERT)
    `CHK(o_res_8bit, b[3])
    `CHK(o_ref_external, b[2] | aux)
    `CHK(o_mux_valid, aux || c == CHAN_XPOS || c == CHAN_YPOS)
    `CHK(o_mux_sel, {c[1], c[2]})
    if (p == PWR_ALWAYS_ON) begin
      `CHK(o_xplate_on, c == CHAN_YPOS)
      `CHK(o_yplate_on, c == CHAN_XPOS)
    end
    if (aux) begin
      `CHK(o_yplate_on, p == PWR_SLEEP_ALERT)
    end
  endtask
  task automatic frame(input logic [7:0] b);
    sent.push_back(b);
    HOST.send(b);
    repeat (20) @(posedge i_clk);
    rd(REG_CTRL, d);
    `CHK(d, sent[$])
  endtask
  task automatic wait_alert(input logic lvl);
    for (int k = 0; k < 20 && o_touch_alert_oe_n !== lvl; k++) @(posedge i_clk);
  endtask
  initial begin
    #2000000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    `CHK(o_touch_alert_oe_n, 1'b1)
    `CHK(o_irq, 1'b0)
    i_sys_rst <= 1'b0;
    rd(REG_CTRL, d);
    `CHK(d, CTRL_RESET)
    rd(4'hF, d);
    `CHK(d, 8'h00)
    for (int p = 0; p < 4; p++) begin
      seed = rnd(seed);
      frame({1'b1, CHAN_AUX_A, seed[1:0], p[1:0]});
      if (p != 2) check_ctrl(sent[$]);
      @(posedge i_clk);
      i_touch_sense_n <= 1'b0;
      repeat (10) @(posedge i_clk);
      `CHK(o_touch_alert_oe_n, p != 0)
      i_touch_sense_n <= 1'b1;
      repeat (6) @(posedge i_clk);
    end
    rd(REG_STATUS, d);
    `CHK(d[2], 1'b1)
    `CHK(d[0], 1'b1)
    for (int i = 0; i < 4; i++) begin
      seed = rnd(seed);
      frame({1'b1, chans[i], seed[3:2], PWR_ALWAYS_ON});
      check_ctrl(sent[$]);
    end
    wr(REG_IRQ_CLR, 8'h07);
    wr(REG_IRQ_EN, 8'h02);
    rd(REG_IRQ_EN, d);
    `CHK(d, 8'h02)
    `CHK(o_irq, 1'b0)
    frame({1'b1, CHAN_AUX_B, 2'b00, PWR_SLEEP_ALERT});
    i_touch_sense_n <= 1'b0;
    wait_alert(1'b0);
    `CHK(o_touch_alert_oe_n, 1'b0)
    `CHK(o_touch_alert_n, 1'b0)
    repeat (2) @(posedge i_clk);
    `CHK(o_irq, 1'b1)
    wr(REG_IRQ_EN, 8'h00);
    #1 `CHK(o_irq, 1'b0)
    wr(REG_IRQ_EN, 8'h02);
    i_touch_sense_n <= 1'b1;
    wait_alert(1'b1);
    `CHK(o_touch_alert_oe_n, 1'b1)
    wr(REG_IRQ_CLR, 8'h02);
    @(posedge i_clk);
    #1 `CHK(o_irq, 1'b0)
    sent.push_back({1'b1, CHAN_YPOS, 2'b00, PWR_ALWAYS_ON});
    wr(REG_CTRL, sent[$]);
    repeat (3) @(posedge i_clk);
    check_ctrl(sent[$]);
    sent.push_back({1'b1, 3'h0, 2'b00, PWR_ALWAYS_ON});
    wr(REG_CTRL, sent[$]);
    repeat (3) @(posedge i_clk);
    check_ctrl(sent[$]);
    conclude();
  end
endmodule

// *** verilog/tpc_ctrl_rx.sv ***
// Serial control byte receiver: hunts a start bit, shifts eight bits.
// Assumes the shift clock is already synchronised to i_clk.
`timescale 1ns/1ps
module tpc_ctrl_rx import tpc_pkg::*; (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_sel_n,
  input  wire logic       i_sclk,
  input  wire logic       i_sdin,
  output logic [7:0]      o_byte,
  output logic            o_byte_vld
);
  logic          sclk_d;
  logic [2:0]    cnt;
  logic [7:0]    shreg;
  tpc_rx_state_t state;
  wire           rise = i_sclk & ~sclk_d;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) sclk_d <= 1'b0;
    else           sclk_d <= i_sclk;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state      <= TPC_IDLE;
      cnt        <= 3'h0;
      shreg      <= 8'h00;
      o_byte     <= CTRL_RESET;
      o_byte_vld <= 1'b0;
    end else begin
      o_byte_vld <= 1'b0;
      if (i_sel_n) begin
        state <= TPC_IDLE;
      end else begin
        case (state)
          TPC_IDLE: begin
            // Input ignored until the first high bit
            if (rise && i_sdin) begin
              shreg <= 8'h01;
              cnt   <= 3'h1;
              state <= TPC_SHIFT;
            end
          end
          TPC_SHIFT: begin
            if (rise) begin
              shreg <= {shreg[6:0], i_sdin};
              cnt   <= cnt + 3'h1;
              if (cnt == 3'h7) begin
                o_byte     <= {shreg[6:0], i_sdin};
                o_byte_vld <= 1'b1;
                state      <= TPC_IDLE;
              end
            end
          end
          default: state <= TPC_IDLE;
        endcase
      end
    end
  end
endmodule

// *** verilog/tpc_pkg.sv ***
// Constants of the touch converter power, pen and plate control block.
// Assumes a single 20 MHz system clock and a sampled serial shift clock.
package tpc_pkg;
  localparam int          CTRL_BITS   = 8;
  localparam int          START_POS   = 7;
  localparam int          CHAN_MSB    = 6;
  localparam int          CHAN_LSB    = 4;
  localparam int          RES_POS     = 3;
  localparam int          REF_POS     = 2;
  localparam int          PWR_MSB     = 1;
  localparam int          PWR_LSB     = 0;
  localparam logic [1:0]  PWR_SLEEP_ALERT = 2'h0;
  localparam logic [1:0]  PWR_SLEEP_QUIET = 2'h1;
  localparam logic [1:0]  PWR_UNUSED      = 2'h2;
  localparam logic [1:0]  PWR_ALWAYS_ON   = 2'h3;
  localparam logic [2:0]  CHAN_XPOS   = 3'h1;
  localparam logic [2:0]  CHAN_YPOS   = 3'h5;
  localparam logic [2:0]  CHAN_AUX_A  = 3'h2;
  localparam logic [2:0]  CHAN_AUX_B  = 3'h6;
  localparam logic [7:0]  CTRL_RESET  = 8'h01;
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h1;
  localparam logic [3:0]  REG_IRQ_EN  = 4'h2;
  localparam logic [3:0]  REG_IRQ_CLR = 4'h3;
  localparam logic [3:0]  REG_STATE   = 4'h4;
  localparam int          EVT_BYTE    = 0;
  localparam int          EVT_TOUCH   = 1;
  localparam int          EVT_BADMODE = 2;
  localparam int          EVT_NUM     = 3;
  typedef enum logic [1:0] {
    TPC_IDLE  = 2'b00,
    TPC_SHIFT = 2'b01,
    TPC_DONE  = 2'b10
  } tpc_rx_state_t;
endpackage

// *** verilog/tpc_sync.sv ***
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time.
`timescale 1ns/1ps
module tpc_sync import tpc_pkg::*; (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta   <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// *** verilog/tpc_top.sv ***
// Power-down, pen alert and plate switch control of a touch converter.
// Assumes pins arrive asynchronously; registers over a plain strobe port.
`timescale 1ns/1ps
module tpc_top import tpc_pkg::*; (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_sel_n,
  input  wire logic       i_serial_shift_clock,
  input  wire logic       i_sdin,
  input  wire logic       i_touch_sense_n,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  output logic            o_irq,
  output logic            o_touch_alert_n,
  output logic            o_touch_alert_oe_n,
  output logic            o_adc_powered,
  output logic            o_xplate_on,
  output logic            o_yplate_on,
  output logic            o_yneg_gnd,
  output logic            o_sense_on_xpos,
  output logic [1:0]      o_mux_sel,
  output logic            o_mux_valid,
  output logic            o_ref_external,
  output logic            o_res_8bit
);
  logic       sel_n_s;
  logic       sclk_s;
  logic       sdin_s;
  logic       touch_n_s;
  logic [7:0] rx_byte;
  logic       rx_vld;
  logic [7:0] ctrl;
  logic [EVT_NUM-1:0] status;
  logic [EVT_NUM-1:0] irq_en;
  logic [EVT_NUM-1:0] next_status;
  logic       alert_en;
  logic       touch_prev;
  logic [2:0] chan;
  logic [1:0] pwr;

  tpc_sync u_sync_sel (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(i_sel_n), .o_sync(sel_n_s));
  tpc_sync u_sync_clk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(i_serial_shift_clock), .o_sync(sclk_s));
  tpc_sync u_sync_din (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(i_sdin), .o_sync(sdin_s));
  tpc_sync u_sync_tch (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_async(i_touch_sense_n), .o_sync(touch_n_s));

  tpc_ctrl_rx u_rx (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_sel_n    (sel_n_s),
    .i_sclk     (sclk_s),
    .i_sdin     (sdin_s),
    .o_byte     (rx_byte),
    .o_byte_vld (rx_vld)
  );

  // Control byte holder: serial byte wins over a register write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst)                       ctrl <= CTRL_RESET;
    else if (rx_vld)                     ctrl <= rx_byte;
    else if (i_wr && i_addr == REG_CTRL) ctrl <= i_wdata;
  end

  assign chan = ctrl[CHAN_MSB:CHAN_LSB];
  assign pwr  = ctrl[PWR_MSB:PWR_LSB];

  // Power mode decode
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      alert_en      <= 1'b0;
      o_adc_powered <= 1'b0;
    end else begin
      case (pwr)
        PWR_SLEEP_ALERT: begin
          alert_en      <= 1'b1;
          o_adc_powered <= 1'b0;
        end
        PWR_SLEEP_QUIET: begin
          alert_en      <= 1'b0;
          o_adc_powered <= 1'b0;
        end
        PWR_ALWAYS_ON: begin
          alert_en      <= 1'b0;
          o_adc_powered <= 1'b1;
        end
        default: begin
          alert_en      <= 1'b0;
          o_adc_powered <= 1'b0;
        end
      endcase
    end
  end

  // Plate switches, mux and reference
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_xplate_on     <= 1'b0;
      o_yplate_on     <= 1'b0;
      o_yneg_gnd      <= 1'b0;
      o_sense_on_xpos <= 1'b0;
      o_mux_sel       <= 2'h0;
      o_mux_valid     <= 1'b0;
      o_ref_external  <= 1'b0;
      o_res_8bit      <= 1'b0;
    end else begin
      o_xplate_on     <= (chan == CHAN_YPOS);
      o_yplate_on     <= (chan == CHAN_XPOS) || (pwr == PWR_SLEEP_ALERT);
      o_yneg_gnd      <= (pwr == PWR_SLEEP_ALERT);
      o_sense_on_xpos <= (pwr == PWR_SLEEP_ALERT);
      case (chan)
        CHAN_XPOS:  begin o_mux_sel <= 2'h0; o_mux_valid <= 1'b1; end
        CHAN_YPOS:  begin o_mux_sel <= 2'h1; o_mux_valid <= 1'b1; end
        CHAN_AUX_A: begin o_mux_sel <= 2'h2; o_mux_valid <= 1'b1; end
        CHAN_AUX_B: begin o_mux_sel <= 2'h3; o_mux_valid <= 1'b1; end
        default:    begin o_mux_sel <= 2'h0; o_mux_valid <= 1'b0; end
      endcase
      // Aux channels always use external reference
      o_ref_external  <= ctrl[REF_POS] || (chan == CHAN_AUX_A) || (chan == CHAN_AUX_B);
      o_res_8bit      <= ctrl[RES_POS];
    end
  end

  // Alert pin: open drain, driven low only on touch while enabled
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_touch_alert_n    <= 1'b1;
      o_touch_alert_oe_n <= 1'b1;
    end else begin
      o_touch_alert_n    <= 1'b0;
      o_touch_alert_oe_n <= ~(alert_en && !touch_n_s);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) touch_prev <= 1'b0;
    else           touch_prev <= alert_en && !touch_n_s;
  end

  // Sticky events; set wins over clear
  always_comb begin
    next_status = status;
    if (i_wr && i_addr == REG_IRQ_CLR) next_status = status & ~i_wdata[EVT_NUM-1:0];
    if (rx_vld)                        next_status[EVT_BYTE] = 1'b1;
    if (alert_en && !touch_n_s && !touch_prev) next_status[EVT_TOUCH] = 1'b1;
    if (rx_vld && rx_byte[PWR_MSB:PWR_LSB] == PWR_UNUSED) next_status[EVT_BADMODE] = 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) status <= '0;
    else           status <= next_status;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst)                         irq_en <= '0;
    else if (i_wr && i_addr == REG_IRQ_EN) irq_en <= i_wdata[EVT_NUM-1:0];
  end

  assign o_irq = |(status & irq_en);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        REG_CTRL:   o_rdata <= ctrl;
        REG_STATUS: o_rdata <= {5'h00, status};
        REG_IRQ_EN: o_rdata <= {5'h00, irq_en};
        REG_STATE:  o_rdata <= {4'h0, alert_en, o_adc_powered, o_xplate_on, o_yplate_on};
        default:    o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  a_mode00_alert: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pwr == PWR_SLEEP_ALERT) |=> alert_en && !o_adc_powered)
    else $error("mode 00 alert not enabled");
  a_mode01_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pwr == PWR_SLEEP_QUIET && chan != CHAN_XPOS) |=> !alert_en && !o_yplate_on)
    else $error("mode 01 wrong");
  a_mode11_power: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pwr == PWR_ALWAYS_ON) |=> o_adc_powered && !alert_en)
    else $error("mode 11 wrong");
  a_mode10_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pwr == PWR_UNUSED) |=> !alert_en)
    else $error("mode 10 alert on");
  a_byte_load: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rx_vld |=> ctrl == $past(rx_byte))
    else $error("byte not applied");
  a_plate_swap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (chan == CHAN_YPOS) ##1 (chan == CHAN_YPOS) |-> o_xplate_on && o_mux_sel == 2'h1)
    else $error("Y+ plate drive wrong");
  a_ref_pick: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (ctrl[REF_POS] && chan == CHAN_XPOS) |=> o_ref_external)
    else $error("reference wrong");
  a_sense_path: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    alert_en |-> ##[0:1] (o_yneg_gnd && o_sense_on_xpos))
    else $error("sense path off");
  a_aux_route: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (chan == CHAN_AUX_B) |=> o_mux_valid && o_mux_sel == 2'h3)
    else $error("aux b route wrong");
  a_res_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ctrl[RES_POS] |=> o_res_8bit)
    else $error("resolution wrong");
  a_touch_alert: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (alert_en && !touch_n_s) ##1 alert_en |-> !o_touch_alert_oe_n)
    else $error("touch not signalled");
endmodule
